// *** rtl/hdlc_access_pkg.sv ***
// How it works
// - bus mode forces nrz; the wired-or line returns on the collision input
// - the shared line counts as idle after eight consecutive sampled ones
// - a pending frame starts only on an idle line; ones follow it
// - without a frame in progress ones are sent: the output holds a one in nrz, its last level in nrzi
// - a sent bit differing from the read-back bit aborts; the frame stays pending
// - a dominant zero wins, so any losing station stops at its first mismatch
// - after a good frame priority drops and ten ones are needed to start
// - a frame sent at lowered priority restores the eight-ones access condition
// - timing mode one drives on the rising edge, checks on the next fall
// - timing mode two drives on a fall and checks one full period later
// - frame rts in clock modes 0,1,4,5 lags data one period, collision-free bits
// - point-to-point links choose nrz or nrzi from a configuration bit
// - nrzi sends and decodes a zero as a level change, one as none
// - serial data leaves on rising clock edges (falling ones in timing mode two) and is sampled on falling ones
// - rts goes low while a frame is pending, or follows a software level
// - a frame starts only while the permit input grants transmission
// - permit loss aborts the frame, which resends when permit returns
// - permit loss past the 32nd data byte drops the frame and flags it
// - with its enable set every permit level change sets a status flag
// - carrier detect comes from aux pin (modes 0,2,3) or clock pin while it is set as an input (4,6,7)
// - with auto-start on and a carrier detect source, the receiver runs only while carrier detect is high
package hdlc_access_pkg;
  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_TX_DATA = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_EXT_IRQ = 8'h10;
  localparam logic [7:0] OFS_RX_DATA = 8'h14;
  localparam int CMD_SEND  = 0;
  localparam int CMD_RESET = 1;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_COLL     = 1;
  localparam int IRQ_CTS_CHG  = 2;
  localparam int IRQ_CTS_FAIL = 3;
  localparam int IRQ_W        = 4;
  localparam int SY_LCLK = 0;
  localparam int SY_AUX  = 1;
  localparam int SY_CX   = 2;
  localparam int SY_CTS  = 3;
  localparam int SY_RXD  = 4;
  localparam int SY_W    = 5;
  localparam int CFG_W   = 13;
  localparam int BUF_DEPTH = 64;
  localparam logic [6:0] BUF_FULL      = 7'h40;
  localparam logic [6:0] LONG_ABORT_AT = 7'h20;
  localparam logic [7:0] FLAG_BYTE     = 8'h7E;
  localparam logic [3:0] IDLE_NORMAL   = 4'h8;
  localparam logic [3:0] IDLE_LOWERED  = 4'hA;
  localparam logic [1:0] TSEL_MODE2    = 2'h3;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [2:0] CM0 = 3'h0;
  localparam logic [2:0] CM1 = 3'h1;
  localparam logic [2:0] CM2 = 3'h2;
  localparam logic [2:0] CM3 = 3'h3;
  localparam logic [2:0] CM4 = 3'h4;
  localparam logic [2:0] CM5 = 3'h5;
  localparam logic [2:0] CM6 = 3'h6;
  localparam logic [2:0] CM7 = 3'h7;

  // channel_config_one / channel_config_two / transmit_count_high bits in one word
  typedef struct packed {
    logic       transmit_clock_pin_pin_direction;  // 1: clock pin is an input
    logic       cas_en;
    logic       clear_to_send_irq_enable;
    logic       rts_sw_level;
    logic       rts_sw_en;
    logic       rts_frame_en;
    logic [2:0] clock_mode;
    logic [1:0] bus_timing_select;
    logic       nrzi_en;
    logic       bus_mode;
  } cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_OPEN  = 2'b01,
    ST_DATA  = 2'b10,
    ST_CLOSE = 2'b11
  } tx_state_t;
endpackage : hdlc_access_pkg

// *** rtl/hdlc_line_access_control.sv ***
// Our own choices: register access over Wishbone and the register addresses.
module hdlc_line_access_control
  import hdlc_access_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        transmit_clock_pin_i,
  input  wire logic        auxiliary_clock_pin_i,
  input  wire logic        collision_feedback_a_i,
  input  wire logic        permit_input_a_n_i,
  input  wire logic        receive_data_i,
  output logic             serial_out_a_o,
  output logic             request_output_a_n_o,
  output logic             irq_o
);
  logic [SY_W-1:0]  sy1_q;
  logic [SY_W-1:0]  sy2_q;
  logic             lclk_d_q;
  logic             rise_w;
  logic             fall_w;
  logic             drive_w;
  cfg_t             cfg_q;
  cfg_t             cfg_d;
  logic             ack_q;
  logic [31:0]      dat_q;
  logic             req_w;
  logic             wr_w;
  logic             rd_w;
  logic [7:0]       buf_q [BUF_DEPTH];
  logic [6:0]       len_q;
  logic             pending_q;
  tx_state_t        state_q;
  logic [7:0]       sh_q;
  logic [2:0]       bit_q;
  logic [6:0]       idx_q;
  logic             line_q;
  logic             sent_q;
  logic             chk_q;
  logic             ok_bit_q;
  logic             rts_frame_n_q;
  logic             rts_n_q;
  logic [3:0]       ones_q;
  logic             lowered_q;
  logic             bus_idle_w;
  logic             cts_ok_w;
  logic             cts_prev_q;
  logic             active_w;
  logic             tx_bit_w;
  logic             start_w;
  logic             coll_w;
  logic             cts_loss_w;
  logic             long_w;
  logic             done_w;
  logic             soft_rst_w;
  logic [IRQ_W-1:0] ext_q;
  logic [IRQ_W-1:0] ext_set_w;
  logic             irq_q;
  logic             cd_avail_w;
  logic             cd_w;
  logic             rx_on_q;
  logic             rx_prev_q;
  logic             rx_bit_w;
  logic [7:0]       rx_sh_q;
  logic [2:0]       rx_cnt_q;
  logic [7:0]       rx_byte_q;
  logic             rx_valid_q;

  // every pin and the link clock cross two flops before any logic looks at them
  genvar g;
  generate
    for (g = 0; g < SY_W; g++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sy1_q[g] <= 1'b1;
          sy2_q[g] <= 1'b1;
        end
        else
        begin
          sy1_q[g] <= (g == SY_LCLK) ? transmit_clock_pin_i :
                      (g == SY_AUX)  ? auxiliary_clock_pin_i :
                      (g == SY_CX)   ? collision_feedback_a_i :
                      (g == SY_CTS)  ? permit_input_a_n_i : receive_data_i;
          sy2_q[g] <= sy1_q[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lclk_d_q <= 1'b1;
    else
      lclk_d_q <= sy2_q[SY_LCLK];
  end

  assign rise_w  = sy2_q[SY_LCLK] & ~lclk_d_q;
  assign fall_w  = ~sy2_q[SY_LCLK] & lclk_d_q;
  // timing mode two launches on the fall; everything else launches on the rise
  assign drive_w = (cfg_q.bus_mode && cfg_q.bus_timing_select == TSEL_MODE2)
                   ? fall_w : rise_w;

  // wishbone classic slave: one wait state, ack for one cycle
  assign req_w = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_w  = req_w & wb_we_i;
  assign rd_w  = req_w & ~wb_we_i;

  always_comb
  begin
    cfg_d = cfg_q;
    if (wb_sel_i[0])
      cfg_d[7:0] = wb_dat_i[7:0];
    if (wb_sel_i[1])
      cfg_d[CFG_W-1:8] = wb_dat_i[CFG_W-1:8];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      cfg_q <= '0;
    end
    else
    begin
      ack_q <= req_w;
      if (wr_w && wb_adr_i == OFS_CONFIG)
        cfg_q <= cfg_d;
      if (rd_w)
      begin
        unique case (wb_adr_i)
          OFS_CONFIG:  dat_q <= {19'h0, cfg_q};
          OFS_STATUS:  dat_q <= {26'h0, len_q == BUF_FULL, rx_on_q, lowered_q,
                                 bus_idle_w, pending_q, active_w};
          OFS_EXT_IRQ: dat_q <= {28'h0, ext_q};
          OFS_RX_DATA: dat_q <= {23'h0, rx_valid_q, rx_byte_q};
          default:     dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  assign soft_rst_w = wr_w && wb_adr_i == OFS_COMMAND && wb_sel_i[0] && wb_dat_i[CMD_RESET];
  assign cts_ok_w   = ~sy2_q[SY_CTS];
  assign active_w   = state_q != ST_IDLE;
  assign bus_idle_w = ones_q >= (lowered_q ? IDLE_LOWERED : IDLE_NORMAL);
  assign tx_bit_w   = active_w ? sh_q[0] : 1'b1;
  assign start_w    = drive_w && !active_w && pending_q && !soft_rst_w && cts_ok_w
                      && (!cfg_q.bus_mode || bus_idle_w);
  // only frame bits are checked; idle ones never count as a collision
  assign coll_w     = fall_w && chk_q && cfg_q.bus_mode && active_w
                      && (sy2_q[SY_CX] != sent_q);
  assign cts_loss_w = active_w && !cts_ok_w;
  assign long_w     = cts_loss_w && idx_q > LONG_ABORT_AT;
  assign done_w     = drive_w && state_q == ST_CLOSE && bit_q == BIT_LAST
                      && !coll_w && !cts_loss_w;

  // frame store: software fills it while nothing is pending; kept for resends
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      len_q     <= 7'h00;
      pending_q <= 1'b0;
    end
    else if (soft_rst_w || long_w || done_w)
    begin
      len_q     <= 7'h00;
      pending_q <= 1'b0;
    end
    else if (wr_w && wb_sel_i[0] && !pending_q)
    begin
      if (wb_adr_i == OFS_TX_DATA && len_q != BUF_FULL)
      begin
        buf_q[len_q[5:0]] <= wb_dat_i[7:0];
        len_q             <= len_q + 7'h01;
      end
      if (wb_adr_i == OFS_COMMAND && wb_dat_i[CMD_SEND] && len_q != 7'h00)
        pending_q <= 1'b1;
    end
  end

  // transmit sequencer; aborts win over the launch edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q  <= ST_IDLE;
      sh_q     <= 8'hFF;
      bit_q    <= 3'h0;
      idx_q    <= 7'h00;
      chk_q    <= 1'b0;
      ok_bit_q <= 1'b0;
    end
    else if (soft_rst_w || coll_w || cts_loss_w)
    begin
      state_q  <= ST_IDLE;
      idx_q    <= 7'h00;
      chk_q    <= 1'b0;
      ok_bit_q <= 1'b0;
    end
    else if (drive_w)
    begin
      chk_q    <= active_w;
      ok_bit_q <= active_w;
      bit_q    <= active_w ? bit_q + 3'h1 : 3'h0;
      sh_q     <= {1'b1, sh_q[7:1]};
      unique case (state_q)
        ST_IDLE:
        begin
          if (start_w)
          begin
            state_q <= ST_OPEN;
            sh_q    <= FLAG_BYTE;
            idx_q   <= 7'h00;
          end
        end
        ST_OPEN:
        begin
          if (bit_q == BIT_LAST)
          begin
            state_q <= ST_DATA;
            sh_q    <= buf_q[0];
            idx_q   <= 7'h01;
          end
        end
        ST_DATA:
        begin
          if (bit_q == BIT_LAST)
          begin
            if (idx_q == len_q)
            begin
              state_q <= ST_CLOSE;
              sh_q    <= FLAG_BYTE;
            end
            else
            begin
              sh_q  <= buf_q[idx_q[5:0]];
              idx_q <= idx_q + 7'h01;
            end
          end
        end
        ST_CLOSE:
        begin
          if (bit_q == BIT_LAST)
            state_q <= ST_IDLE;
        end
      endcase
    end
    else if (fall_w)
      chk_q <= 1'b0;
  end

  // line coding; bus mode is always nrz so the read-back compares directly
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      line_q <= 1'b1;
      sent_q <= 1'b1;
    end
    else if (drive_w)
    begin
      sent_q <= tx_bit_w;
      if (cfg_q.bus_mode || !cfg_q.nrzi_en)
        line_q <= tx_bit_w;
      else if (!tx_bit_w)
        line_q <= ~line_q;
    end
  end

  assign serial_out_a_o = line_q;

  // consecutive ones on the shared line, saturating at the longer threshold
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ones_q <= 4'h0;
    else if (fall_w)
      ones_q <= !sy2_q[SY_CX] ? 4'h0 :
                (ones_q == IDLE_LOWERED) ? ones_q : ones_q + 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_w)
      lowered_q <= 1'b0;
    else if (done_w && cfg_q.bus_mode)
      lowered_q <= !lowered_q;
  end

  // rts: software level, bus frame marker one period late, or pending request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rts_frame_n_q <= 1'b1;
      rts_n_q       <= 1'b1;
    end
    else
    begin
      if (drive_w)
        rts_frame_n_q <= !(ok_bit_q && !coll_w);
      else if (coll_w)
        rts_frame_n_q <= 1'b1;
      if (cfg_q.rts_sw_en)
        rts_n_q <= cfg_q.rts_sw_level;
      else if (cfg_q.bus_mode && cfg_q.rts_frame_en && (cfg_q.clock_mode == CM0
               || cfg_q.clock_mode == CM1 || cfg_q.clock_mode == CM4
               || cfg_q.clock_mode == CM5))
        rts_n_q <= rts_frame_n_q;
      else
        rts_n_q <= !pending_q;
    end
  end

  assign request_output_a_n_o = rts_n_q;

  // status flags: hardware set beats a software write-one clear
  always_comb
  begin
    ext_set_w               = '0;
    ext_set_w[IRQ_DONE]     = done_w;
    ext_set_w[IRQ_COLL]     = coll_w;
    ext_set_w[IRQ_CTS_CHG]  = cfg_q.clear_to_send_irq_enable
                              && (sy2_q[SY_CTS] != cts_prev_q);
    ext_set_w[IRQ_CTS_FAIL] = long_w;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_q      <= '0;
      irq_q      <= 1'b0;
      cts_prev_q <= 1'b1;
    end
    else
    begin
      cts_prev_q <= sy2_q[SY_CTS];
      if (wr_w && wb_adr_i == OFS_EXT_IRQ && wb_sel_i[0])
        ext_q <= (ext_q & ~wb_dat_i[IRQ_W-1:0]) | ext_set_w;
      else
        ext_q <= ext_q | ext_set_w;
      irq_q <= |ext_q;
    end
  end

  assign irq_o = irq_q;

  // carrier detect source follows the clock mode; mode 1 and 5 have none
  always_comb
  begin
    cd_avail_w = 1'b0;
    cd_w       = 1'b0;
    unique case (cfg_q.clock_mode)
      CM0, CM2, CM3:
      begin
        cd_avail_w = 1'b1;
        cd_w       = sy2_q[SY_AUX];
      end
      CM4, CM6, CM7:
      begin
        cd_avail_w = cfg_q.transmit_clock_pin_pin_direction;
        cd_w       = sy2_q[SY_LCLK];
      end
      default:
      begin
        cd_avail_w = 1'b0;
        cd_w       = 1'b0;
      end
    endcase
  end

  assign rx_bit_w = (cfg_q.nrzi_en && !cfg_q.bus_mode)
                    ? (sy2_q[SY_RXD] == rx_prev_q) : sy2_q[SY_RXD];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_on_q    <= 1'b0;
      rx_prev_q  <= 1'b1;
      rx_sh_q    <= 8'h00;
      rx_cnt_q   <= 3'h0;
      rx_byte_q  <= 8'h00;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_on_q <= !(cfg_q.cas_en && cd_avail_w) || cd_w;
      if (rd_w && wb_adr_i == OFS_RX_DATA)
        rx_valid_q <= 1'b0;
      if (!rx_on_q)
        rx_cnt_q <= 3'h0;
      else if (fall_w)
      begin
        rx_prev_q <= sy2_q[SY_RXD];
        rx_sh_q   <= {rx_bit_w, rx_sh_q[7:1]};
        rx_cnt_q  <= rx_cnt_q + 3'h1;
        if (rx_cnt_q == BIT_LAST)
        begin
          rx_byte_q  <= {rx_bit_w, rx_sh_q[7:1]};
          rx_valid_q <= 1'b1;
        end
      end
    end
  end

  idle_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_w && cfg_q.bus_mode |-> ones_q >= IDLE_NORMAL)
    else $error("frame started on a busy line");
  idle_ones_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_w && cfg_q.bus_mode && state_q == ST_IDLE && !start_w |=> line_q)
    else $error("idle output not high");
  coll_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
    coll_w |=> state_q == ST_IDLE && pending_q && ext_q[IRQ_COLL])
    else $error("collision did not abort");
  prio_ten_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_w && cfg_q.bus_mode && lowered_q |-> ones_q == IDLE_LOWERED)
    else $error("lowered priority ignored");
  prio_restore_a: assert property (@(posedge clk_i) disable iff (rst_i)
    done_w && cfg_q.bus_mode |=> lowered_q != $past(lowered_q))
    else $error("priority not rotated");
  cts_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_q == ST_OPEN) |-> $past(cts_ok_w))
    else $error("start without permit");
  cts_resend_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cts_loss_w && !long_w && !done_w |=> !active_w && pending_q)
    else $error("permit loss not recovered");
  long_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    long_w && !cfg_q.rts_sw_en && !cfg_q.bus_mode
    |=> !pending_q && ext_q[IRQ_CTS_FAIL] ##1 rts_n_q)
    else $error("long frame not dropped");
  nrzi_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_w && !cfg_q.bus_mode && cfg_q.nrzi_en && !tx_bit_w
    |=> line_q != $past(line_q))
    else $error("nrzi zero without change");
  cas_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_q.cas_en && cd_avail_w && !cd_w ##1 $stable(cfg_q) |-> !rx_on_q)
    else $error("receiver on without carrier");
endmodule : hdlc_line_access_control

// *** dv/line_partner.sv ***
module line_partner (
  input  wire logic run_i,
  input  wire logic jam_i,
  input  wire logic tx_i,
  output logic      lclk_o,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // the far clock rests low when the bench stops it, as a modem would
  initial lclk_o = 1'h0;
  always
  begin
    #160;
    lclk_o = run_i ? ~lclk_o : 1'h0;
  end
  // shared line with a pull-up: any station sending zero wins it
  assign line_o = tx_i & ~jam_i;
endmodule : line_partner

// *** dv/tb_top.sv ***
module tb_top
  import hdlc_access_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        permit_n = 1'h1;
  logic        aux = 1'h0;
  logic        run = 1'h0;
  logic        jam = 1'h0;
  logic        tx;
  logic        req_n;
  logic        irq;
  logic        lclk;
  logic        line;
  logic [23:0] fr;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n;

  always #20 clk_i = ~clk_i;

  hdlc_line_access_control u_hdlc_line_access_control (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .wb_cyc_i              (cyc),
    .wb_stb_i              (stb),
    .wb_we_i               (we),
    .wb_adr_i              (adr),
    .wb_dat_i              (wdat),
    .wb_sel_i              (4'hF),
    .wb_dat_o              (rdat),
    .wb_ack_o              (ack),
    .transmit_clock_pin_i  (lclk),
    .auxiliary_clock_pin_i (aux),
    .collision_feedback_a_i(line),
    .permit_input_a_n_i    (permit_n),
    .receive_data_i        (line),
    .serial_out_a_o        (tx),
    .request_output_a_n_o  (req_n),
    .irq_o                 (irq)
  );

  line_partner u_line_partner (
    .run_i (run),
    .jam_i (jam),
    .tx_i  (tx),
    .lclk_o(lclk),
    .line_o(line)
  );

  task automatic close_out;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // a slave that never answers ends the run instead of hanging it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'h1 && k < 20);
    if (k >= 20)
    begin
      n_fail++;
      close_out();
    end
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdc

  task automatic cw(input int c);
    repeat (c) @(posedge clk_i);
  endtask : cw

  task automatic tick(input int c);
    repeat (c) @(posedge lclk);
  endtask : tick

  task automatic setp(input logic v);
    @(posedge clk_i);
    permit_n <= v;
  endtask : setp

  // jam changes just after a far clock rise so whole bit periods are counted
  task automatic setj(input logic v);
    @(posedge lclk);
    @(posedge clk_i);
    jam <= v;
  endtask : setj

  task automatic send(input logic [7:0] d);
    wb(1'h1, OFS_TX_DATA, {24'h0, d});
    wb(1'h1, OFS_COMMAND, 32'h1);
    cw(2);
  endtask : send

  task automatic clr;
    wb(1'h1, OFS_EXT_IRQ, 32'hF);
  endtask : clr

  task automatic le(input logic fall);
    if (fall)
      @(negedge lclk);
    else
      @(posedge lclk);
  endtask : le

  // tx is sampled on the next launch edge, a full period after the bit left
  task automatic start(input logic fall);
    n = 0;
    do
    begin
      le(fall);
      n++;
    end
    while (tx !== 1'h0 && n < 400);
    if (n >= 400)
    begin
      n_fail++;
      close_out();
    end
  endtask : start

  task automatic cap(input logic fall);
    start(fall);
    fr = 24'h0;
    for (int i = 1; i < 24; i++)
    begin
      le(fall);
      fr[i] = tx;
    end
  endtask : cap

  task automatic ones(input int c);
    int k;
    k = 0;
    repeat (c)
    begin
      @(posedge lclk);
      if (tx === 1'h1)
        k++;
    end
    chk(32'(k), 32'(c));
  endtask : ones

  function automatic logic [31:0] fx(input logic [7:0] d);
    return {8'h00, FLAG_BYTE, d, FLAG_BYTE};
  endfunction : fx

  task automatic t_p2p;
    wb(1'h1, OFS_CONFIG, 32'h0);
    setp(1'h0);  // permit held for the whole frame
    send(8'hA5);
    chk({31'h0, req_n}, 32'h0);
    cap(1'h0);
    chk({8'h00, fr}, fx(8'hA5));
    tick(3);
    chk({31'h0, irq}, 32'h1);
    rdc(OFS_EXT_IRQ, 32'hF, 32'h1);
    rdc(OFS_RX_DATA, 32'h100, 32'h100);
    chk({31'h0, req_n}, 32'h1);
    clr();
  endtask : t_p2p

  task automatic t_nrzi;
    logic [23:0] dec;
    logic        p;
    wb(1'h1, OFS_CONFIG, 32'h2);
    send(8'h3C);
    cap(1'h0);
    p = 1'h1;
    for (int i = 0; i < 24; i++)
    begin
      dec[i] = (fr[i] === p);
      p = fr[i];
    end
    chk({8'h00, dec}, fx(8'h3C));
    tick(3);
    clr();
  endtask : t_nrzi

  task automatic t_permit;
    wb(1'h1, OFS_CONFIG, 32'h0);
    setp(1'h1);
    send(8'h5A);
    chk({31'h0, req_n}, 32'h0);
    ones(12);
    setp(1'h0);
    start(1'h0);
    tick(4);
    setp(1'h1);
    tick(2);
    ones(6);
    setp(1'h0);
    cap(1'h0);
    chk({8'h00, fr}, fx(8'h5A));
    tick(3);
    rdc(OFS_EXT_IRQ, 32'hF, 32'h1);
    clr();
  endtask : t_permit

  task automatic t_long;
    wb(1'h1, OFS_CONFIG, 32'h0);
    for (int i = 0; i < 40; i++)
      wb(1'h1, OFS_TX_DATA, 32'(i));
    wb(1'h1, OFS_COMMAND, 32'h1);
    start(1'h0);
    tick(8 + 8 * 33 + 3);
    setp(1'h1);
    tick(4);
    rdc(OFS_EXT_IRQ, 32'hF, 32'h8);
    chk({31'h0, req_n}, 32'h1);
    rdc(OFS_STATUS, 32'h3, 32'h0);
    setp(1'h0);
    ones(12);
    clr();
  endtask : t_long

  task automatic t_bus;
    wb(1'h1, OFS_CONFIG, 32'h5);
    setj(1'h1);
    send(8'h81);
    ones(16);
    rdc(OFS_EXT_IRQ, 32'hF, 32'h0);
    setj(1'h0);
    start(1'h0);
    chk({31'h0, n inside {[9:11]}}, 32'h1);
    tick(2);
    setj(1'h1);
    tick(2);
    ones(4);
    rdc(OFS_EXT_IRQ, 32'h2, 32'h2);
    setj(1'h0);
    cap(1'h0);
    chk({8'h00, fr}, fx(8'h81));
    tick(3);
    rdc(OFS_STATUS, 32'h8, 32'h8);
    clr();
    setj(1'h1);
    send(8'h42);
    setj(1'h0);
    start(1'h0);
    chk({31'h0, n inside {[11:13]}}, 32'h1);
    tick(28);
    rdc(OFS_STATUS, 32'h8, 32'h0);
    clr();
    wb(1'h1, OFS_CONFIG, 32'hD);
    send(8'h24);
    cap(1'h1);
    chk({8'h00, fr}, fx(8'h24));
    tick(3);
    clr();
  endtask : t_bus

  task automatic t_misc;
    wb(1'h1, OFS_CONFIG, 32'h100);
    cw(2);
    chk({31'h0, req_n}, 32'h0);
    wb(1'h1, OFS_CONFIG, 32'h300);
    cw(2);
    chk({31'h0, req_n}, 32'h1);
    wb(1'h1, OFS_CONFIG, 32'h400);
    clr();
    setp(1'h1);
    cw(8);
    rdc(OFS_EXT_IRQ, 32'h4, 32'h4);
    wb(1'h1, OFS_EXT_IRQ, 32'h4);
    setp(1'h0);
    cw(8);
    rdc(OFS_EXT_IRQ, 32'h4, 32'h4);
    wb(1'h1, OFS_CONFIG, 32'h0);
    clr();
    setp(1'h1);
    cw(8);
    rdc(OFS_EXT_IRQ, 32'h4, 32'h0);
    setp(1'h0);
    wb(1'h1, OFS_CONFIG, 32'h85);
    send(8'h11);
    start(1'h0);
    tick(3);
    chk({31'h0, req_n}, 32'h0);
    tick(24);
    chk({31'h0, req_n}, 32'h1);
    clr();
    run <= 1'h0;
    wb(1'h1, OFS_CONFIG, 32'h800);
    cw(12);
    rdc(OFS_STATUS, 32'h10, 32'h0);
    @(posedge clk_i);
    aux <= 1'h1;
    cw(4);
    rdc(OFS_STATUS, 32'h10, 32'h10);
    wb(1'h1, OFS_CONFIG, 32'h1840);
    cw(4);
    rdc(OFS_STATUS, 32'h10, 32'h0);
    @(posedge clk_i);
    aux <= 1'h0;
    wb(1'h1, OFS_CONFIG, 32'h810);
    cw(4);
    rdc(OFS_STATUS, 32'h10, 32'h10);
  endtask : t_misc

  // reset is synchronous, so two edges also load the sync flops
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    chk({29'h0, tx, req_n, irq}, 32'h6);
    wb(1'h1, 8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'hFFFF_FFFF, 32'h0);
    run <= 1'h1;
    t_p2p();
    t_nrzi();
    t_permit();
    t_long();
    t_bus();
    t_misc();
    close_out();
  end

  initial
  begin
    #2000000;
    n_fail++;
    close_out();
  end
endmodule : tb_top
